/* rfd_core.sv */
/*
  Instruction decoder and executor for a 14-bit instruction word, 8-bit data core.
  Assumes program memory and the external file registers answer combinationally
  on the same clock, and that the port pins and wake input are asynchronous.
*/
// Chosen here: the placing of the registers and the plain strobed port.
// Behaviour
// - Bit clear/set read the whole register, change one bit, write the byte back.
// - Prefix 00 nibble 0100 ORs accumulator with file, only zero flag changes.
// - Prefix 00 nibble 0110 XORs accumulator with file, only zero flag changes.
// - Nibble 1011 decrements file, skips next on zero, no flags, two cycles if skipping.
// - Nibble 1111 increments file, skips next on zero, no flags, two cycles if skipping.
// - Nibble 1100 rotates file right through carry, only carry changes.
// - Nibble 1101 rotates file left through carry, only carry changes.
// - Bit test 10bb skips next when the bit is zero, two cycles when skipping.
// - Bit test 11bb skips next when the bit is one, two cycles when skipping.
// - Literal nibble 1000 ORs literal into accumulator in one cycle, updates zero.
// - Literal nibble 1010 XORs literal into accumulator in one cycle, only zero.
// - Literal 110x computes literal minus accumulator, updates carry, half carry, zero.
// - Literal 01xx loads literal into accumulator and returns, two cycles.
// - Fixed standby word enters standby, updating timeout and power-down flags.
// - Self-modifying access to the port register reads the pins, not the latch.
// - Writing the timer register clears the prescaler when assigned to it.
// - PC change or true test takes two cycles, second is a no-operation.
// - Destination bit zero writes accumulator, one writes the file register.
// - Seven-bit file field addresses registers 0x00 to 0x7F.
// - Each instruction cycle spans four clock periods.
`timescale 1ns/10ps
`default_nettype none
module rfd_core
  import rfd_pkg::*;
(
  input  wire logic        clk_sys_i,
  input  wire logic        arst_n_i,
  output logic [10:0]      prog_addr_o,
  input  wire logic [13:0] prog_data_i,
  output logic [6:0]       file_addr_o,
  input  wire logic [7:0]  file_rd_data_i,
  output logic             file_wr_o,
  output logic [6:0]       file_wr_addr_o,
  output logic [7:0]       file_wr_data_o,
  input  wire logic [7:0]  port_pins_i,
  input  wire logic        psc_on_timer_i,
  input  wire logic        wake_i,
  output logic             psc_clear_o,
  output logic             wdt_kick_o,
  output logic             int_return_o,
  output logic             sleeping_o,
  output logic [7:0]       acc_o,
  output logic [7:0]       status_o
);

  // Sum with carry out and nibble carry, shared by the add and subtract forms.
  function automatic logic [9:0] add8(input logic [7:0] a, input logic [7:0] b,
                                      input logic cin);
    logic [4:0] lo;
    logic [8:0] full;
    lo   = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    return {full[8], lo[4], full[7:0]};
  endfunction : add8

  logic       rst_s1_ff;
  logic       rst_n_ff;
  rfd_regs_t  q_ff;
  rfd_regs_t  nxt_q;
  logic       ex_go;
  logic [7:0] fval;
  logic [7:0] status_byte;

  // Reset is released through two flip-flops so release never races the clock.
  always_ff @(posedge clk_sys_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff  <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff  <= rst_s1_ff;
    end
  end

  // Execution happens on the last clock of a normal instruction cycle.
  assign ex_go = (q_ff.phase == PH_LAST) && (q_ff.st == RFD_RUN);
  assign status_byte = {3'h0, q_ff.to, q_ff.pd, q_ff.z, q_ff.dc, q_ff.c};

  // Operand source: core registers, the synchronised pins for the port, else the file.
  always_comb begin
    case (q_ff.ir[6:0])
      FA_PCL:     fval = q_ff.pc[7:0];
      FA_STATUS:  fval = status_byte;
      FA_PCLATCH: fval = {5'h00, q_ff.pclatch};
      FA_PORT:    fval = q_ff.pin_s2;
      default:    fval = file_rd_data_i;
    endcase
  end

  // Whole next-state computation of the core.
  always_comb begin
    logic [3:0]  nib;
    logic [7:0]  k;
    logic [7:0]  res;
    logic [9:0]  sum;
    logic [2:0]  bsel;
    logic        dst_f;
    logic        dst_w;
    logic        up_z;
    logic        up_c;
    logic        up_dc;
    logic        nc;
    logic        ndc;
    logic        skip;
    logic        jump;
    nib   = q_ff.ir[11:8];
    k     = q_ff.ir[7:0];
    bsel  = q_ff.ir[9:7];
    res   = 8'h00;
    sum   = 10'h000;
    dst_f = 1'b0;
    dst_w = 1'b0;
    up_z  = 1'b0;
    up_c  = 1'b0;
    up_dc = 1'b0;
    nc    = q_ff.c;
    ndc   = q_ff.dc;
    skip  = 1'b0;
    jump  = 1'b0;
    nxt_q = q_ff;
    nxt_q.pin_s1  = port_pins_i;
    nxt_q.pin_s2  = q_ff.pin_s1;
    nxt_q.wake_s1 = wake_i;
    nxt_q.wake_s2 = q_ff.wake_s1;
    nxt_q.wr      = 1'b0;
    nxt_q.psc_clr = 1'b0;
    nxt_q.kick    = 1'b0;
    nxt_q.rfi     = 1'b0;
    nxt_q.phase   = q_ff.phase + 2'h1;
    // Fetch at the first clock; a skipped word is fetched and thrown away.
    if (q_ff.phase == PH_FETCH && q_ff.st != RFD_SLEEP) begin
      nxt_q.ir = prog_data_i;
      if (q_ff.st != RFD_BRANCH) begin
        nxt_q.pc = q_ff.pc + 11'h001;
      end
    end
    // The flush cycle ends as a no-operation and normal flow resumes.
    if (q_ff.phase == PH_LAST && (q_ff.st == RFD_SKIP || q_ff.st == RFD_BRANCH)) begin
      nxt_q.st = RFD_RUN;
    end
    if (q_ff.phase == PH_LAST && q_ff.st == RFD_SLEEP && q_ff.wake_s2) begin
      nxt_q.st = RFD_RUN;
    end
    if (ex_go) begin
      dst_f = q_ff.ir[7];
      dst_w = !q_ff.ir[7];
      case (q_ff.ir[13:12])
        2'b00: begin
          case (nib)
            OP_MISC: begin
              dst_w = 1'b0;
              res   = q_ff.acc;
              if (q_ff.ir == W_RETURN || q_ff.ir == W_RETURN_FROM_INTERRUPT) begin
                nxt_q.sp = q_ff.sp - 3'h1;
                nxt_q.pc = q_ff.stack[q_ff.sp - 3'h1];
                nxt_q.rfi = (q_ff.ir == W_RETURN_FROM_INTERRUPT);
                jump = 1'b1;
              end else if (q_ff.ir == W_SLEEP) begin
                nxt_q.to = 1'b1;
                nxt_q.pd = 1'b0;
                nxt_q.st = RFD_SLEEP;
              end else if (q_ff.ir == W_KICK) begin
                nxt_q.to   = 1'b1;
                nxt_q.pd   = 1'b1;
                nxt_q.kick = 1'b1;
              end
            end
            OP_CLR:   begin res = 8'h00; up_z = 1'b1; end
            OP_SUB:   begin
              sum = add8(fval, ~q_ff.acc, 1'b1);
              res = sum[7:0]; nc = sum[9]; ndc = sum[8];
              up_z = 1'b1; up_c = 1'b1; up_dc = 1'b1;
            end
            OP_DEC:   begin res = fval - 8'h01; up_z = 1'b1; end
            OP_IOR:   begin res = q_ff.acc | fval; up_z = 1'b1; end
            OP_AND:   begin res = q_ff.acc & fval; up_z = 1'b1; end
            OP_XOR:   begin res = q_ff.acc ^ fval; up_z = 1'b1; end
            OP_ADD:   begin
              sum = add8(fval, q_ff.acc, 1'b0);
              res = sum[7:0]; nc = sum[9]; ndc = sum[8];
              up_z = 1'b1; up_c = 1'b1; up_dc = 1'b1;
            end
            OP_MOV:   begin res = fval; up_z = 1'b1; end
            OP_COM:   begin res = ~fval; up_z = 1'b1; end
            OP_INC:   begin res = fval + 8'h01; up_z = 1'b1; end
            OP_DECSZ: begin res = fval - 8'h01; skip = (res == 8'h00); end
            OP_INCSZ: begin res = fval + 8'h01; skip = (res == 8'h00); end
            OP_RRC:   begin res = {q_ff.c, fval[7:1]}; nc = fval[0]; up_c = 1'b1; end
            OP_RLC:   begin res = {fval[6:0], q_ff.c}; nc = fval[7]; up_c = 1'b1; end
            default:  begin res = {fval[3:0], fval[7:4]}; end
          endcase
        end
        2'b01: begin
          // Bit operations always work on the full byte read back.
          dst_w = 1'b0;
          dst_f = !q_ff.ir[11];
          res   = fval;
          res[bsel] = q_ff.ir[10];
          if (q_ff.ir[11]) begin
            // Bit 10 holds the level that makes the test true: clear skips on 0, set on 1.
            skip = (fval[bsel] == q_ff.ir[10]);
          end
        end
        2'b10: begin
          dst_w = 1'b0;
          dst_f = 1'b0;
          if (!q_ff.ir[11]) begin
            nxt_q.stack[q_ff.sp] = q_ff.pc;
            nxt_q.sp = q_ff.sp + 3'h1;
          end
          nxt_q.pc = {q_ff.ir[10:0]};
          jump = 1'b1;
        end
        default: begin
          dst_f = 1'b0;
          dst_w = 1'b1;
          casez (nib)
            4'b00??: res = k;
            4'b01??: begin
              res = k;
              nxt_q.sp = q_ff.sp - 3'h1;
              nxt_q.pc = q_ff.stack[q_ff.sp - 3'h1];
              jump = 1'b1;
            end
            LOP_IOR: begin res = q_ff.acc | k; up_z = 1'b1; end
            LOP_AND: begin res = q_ff.acc & k; up_z = 1'b1; end
            LOP_XOR: begin res = q_ff.acc ^ k; up_z = 1'b1; end
            4'b110?: begin
              sum = add8(k, ~q_ff.acc, 1'b1);
              res = sum[7:0]; nc = sum[9]; ndc = sum[8];
              up_z = 1'b1; up_c = 1'b1; up_dc = 1'b1;
            end
            default: begin
              sum = add8(k, q_ff.acc, 1'b0);
              res = sum[7:0]; nc = sum[9]; ndc = sum[8];
              up_z = 1'b1; up_c = 1'b1; up_dc = 1'b1;
            end
          endcase
        end
      endcase
      if (dst_w) begin
        nxt_q.acc = res;
      end
      // A file write lands first; the instruction's own flags then override it.
      if (dst_f) begin
        case (q_ff.ir[6:0])
          FA_STATUS: begin
            nxt_q.c  = res[SB_C];
            nxt_q.dc = res[SB_DC];
            nxt_q.z  = res[SB_Z];
          end
          FA_PCL: begin
            nxt_q.pc = {q_ff.pclatch, res};
            jump = 1'b1;
          end
          FA_PCLATCH: nxt_q.pclatch = res[2:0];
          default: begin
            nxt_q.wr      = 1'b1;
            nxt_q.wr_addr = q_ff.ir[6:0];
            nxt_q.wr_data = res;
            nxt_q.psc_clr = (q_ff.ir[6:0] == FA_TIMER) && psc_on_timer_i;
          end
        endcase
      end
      if (up_z) begin
        nxt_q.z = (res == 8'h00);
      end
      if (up_c) begin
        nxt_q.c = nc;
      end
      if (up_dc) begin
        nxt_q.dc = ndc;
      end
      if (jump) begin
        nxt_q.st = RFD_BRANCH;
      end else if (skip) begin
        nxt_q.st = RFD_SKIP;
      end
    end
  end

  // Single register stage for the whole core state.
  always_ff @(posedge clk_sys_i or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      q_ff       <= '0;
      q_ff.st    <= RFD_RUN;
      q_ff.pc    <= PC_RST;
      q_ff.acc   <= ACC_RST;
      q_ff.to    <= TO_RST;
      q_ff.pd    <= PD_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign prog_addr_o    = q_ff.pc;
  assign file_addr_o    = q_ff.ir[6:0];
  assign file_wr_o      = q_ff.wr;
  assign file_wr_addr_o = q_ff.wr_addr;
  assign file_wr_data_o = q_ff.wr_data;
  assign psc_clear_o    = q_ff.psc_clr;
  assign wdt_kick_o     = q_ff.kick;
  assign int_return_o   = q_ff.rfi;
  assign sleeping_o     = (q_ff.st == RFD_SLEEP);
  assign acc_o          = q_ff.acc;
  assign status_o       = status_byte;

  // The four phases follow in a fixed order.
  sequence s_icycle;
    q_ff.phase == 2'h0 ##1 q_ff.phase == 2'h1 ##1 q_ff.phase == 2'h2 ##1 q_ff.phase == 2'h3;
  endsequence
  property p_icycle;
    @(posedge clk_sys_i) disable iff (!rst_n_ff) q_ff.phase == 2'h0 |-> s_icycle;
  endproperty
  a_icycle: assert property (p_icycle) else $error("phase order broken");

  property p_bit_rmw;
    @(posedge clk_sys_i) disable iff (!rst_n_ff)
      ex_go && q_ff.ir[13:11] == 3'b010 && q_ff.ir[6:0] > FA_PCLATCH
      |=> file_wr_o && file_wr_data_o[$past(q_ff.ir[9:7])] == $past(q_ff.ir[10]);
  endproperty
  a_bit_rmw: assert property (p_bit_rmw) else $error("bit op write-back wrong");

  property p_ior_flags;
    @(posedge clk_sys_i) disable iff (!rst_n_ff)
      ex_go && q_ff.ir[13:8] == 6'h04 && q_ff.ir[6:0] != FA_STATUS
      |=> q_ff.c == $past(q_ff.c) && q_ff.z == ($past(q_ff.acc | fval) == 8'h00);
  endproperty
  a_ior_flags: assert property (p_ior_flags) else $error("or changed wrong flags");

  property p_decsz;
    @(posedge clk_sys_i) disable iff (!rst_n_ff)
      ex_go && q_ff.ir[13:8] == 6'h0b && fval == 8'h01 |=> q_ff.st == RFD_SKIP;
  endproperty
  a_decsz: assert property (p_decsz) else $error("decrement skip missing");

  property p_rrc;
    @(posedge clk_sys_i) disable iff (!rst_n_ff)
      ex_go && q_ff.ir[13:8] == 6'h0c && q_ff.ir[6:0] != FA_STATUS |=> q_ff.c == $past(fval[0]);
  endproperty
  a_rrc: assert property (p_rrc) else $error("rotate right carry wrong");

  property p_test_clr;
    @(posedge clk_sys_i) disable iff (!rst_n_ff)
      ex_go && q_ff.ir[13:10] == 4'h6 && !fval[q_ff.ir[9:7]] |=> q_ff.st == RFD_SKIP;
  endproperty
  a_test_clr: assert property (p_test_clr) else $error("bit test skip missing");

  property p_return_with_literal;
    @(posedge clk_sys_i) disable iff (!rst_n_ff)
      ex_go && q_ff.ir[13:10] == 4'hd
      |=> q_ff.acc == $past(q_ff.ir[7:0]) && q_ff.st == RFD_BRANCH ##4 q_ff.st == RFD_RUN;
  endproperty
  a_return_with_literal: assert property (p_return_with_literal) else $error("return with literal wrong");

  property p_standby;
    @(posedge clk_sys_i) disable iff (!rst_n_ff)
      ex_go && q_ff.ir == W_SLEEP |=> !q_ff.pd && q_ff.to && sleeping_o;
  endproperty
  a_standby: assert property (p_standby) else $error("standby entry wrong");

  property p_psc;
    @(posedge clk_sys_i) disable iff (!rst_n_ff)
      ex_go && q_ff.ir[13:12] == 2'b00 && q_ff.ir[7] && q_ff.ir[6:0] == FA_TIMER
      && psc_on_timer_i |=> psc_clear_o && file_wr_o;
  endproperty
  a_psc: assert property (p_psc) else $error("prescaler not cleared");

  property p_flush;
    @(posedge clk_sys_i) disable iff (!rst_n_ff)
      q_ff.st == RFD_SKIP && q_ff.phase == 2'h3 |=> q_ff.st == RFD_RUN && !file_wr_o;
  endproperty
  a_flush: assert property (p_flush) else $error("flush cycle not a no-op");

endmodule : rfd_core
`default_nettype wire

/* rfd_pkg.sv */
/*
  Constants, enumerations and the state record of the 14-bit instruction decoder core.
  Assumes it is compiled before the core module that imports it.
*/
`default_nettype none
package rfd_pkg;
  // Each instruction cycle spans four oscillator periods, one per clock.
  localparam logic [1:0]  PH_LAST      = 2'h3;
  localparam logic [1:0]  PH_FETCH     = 2'h0;
  // Registers that live inside the core or are read or written in a special way.
  localparam logic [6:0]  FA_TIMER     = 7'h01;
  localparam logic [6:0]  FA_PCL       = 7'h02;
  localparam logic [6:0]  FA_STATUS    = 7'h03;
  localparam logic [6:0]  FA_PORT      = 7'h05;
  localparam logic [6:0]  FA_PCLATCH   = 7'h0a;
  // Status byte field positions.
  localparam int          SB_C         = 0;
  localparam int          SB_DC        = 1;
  localparam int          SB_Z         = 2;
  localparam int          SB_PD        = 3;
  localparam int          SB_TO        = 4;
  // Values after reset.
  localparam logic [10:0] PC_RST       = 11'h000;
  localparam logic [7:0]  ACC_RST      = 8'h00;
  localparam logic        TO_RST       = 1'b1;
  localparam logic        PD_RST       = 1'b1;
  // Byte-oriented opcode nibbles under prefix 00.
  localparam logic [3:0]  OP_MISC      = 4'h0;
  localparam logic [3:0]  OP_CLR       = 4'h1;
  localparam logic [3:0]  OP_SUB       = 4'h2;
  localparam logic [3:0]  OP_DEC       = 4'h3;
  localparam logic [3:0]  OP_IOR       = 4'h4;
  localparam logic [3:0]  OP_AND       = 4'h5;
  localparam logic [3:0]  OP_XOR       = 4'h6;
  localparam logic [3:0]  OP_ADD       = 4'h7;
  localparam logic [3:0]  OP_MOV       = 4'h8;
  localparam logic [3:0]  OP_COM       = 4'h9;
  localparam logic [3:0]  OP_INC       = 4'ha;
  localparam logic [3:0]  OP_DECSZ     = 4'hb;
  localparam logic [3:0]  OP_RRC       = 4'hc;
  localparam logic [3:0]  OP_RLC       = 4'hd;
  localparam logic [3:0]  OP_SWAP      = 4'he;
  localparam logic [3:0]  OP_INCSZ     = 4'hf;
  // Literal nibbles under prefix 11.
  localparam logic [3:0]  LOP_IOR      = 4'h8;
  localparam logic [3:0]  LOP_AND      = 4'h9;
  localparam logic [3:0]  LOP_XOR      = 4'ha;
  // Fixed control words.
  localparam logic [13:0] W_RETURN     = 14'h0008;
  localparam logic [13:0] W_RETURN_FROM_INTERRUPT     = 14'h0009;
  localparam logic [13:0] W_SLEEP      = 14'h0063;
  localparam logic [13:0] W_KICK       = 14'h0064;

  typedef enum logic [3:0] {
    RFD_RUN    = 4'h1,
    RFD_SKIP   = 4'h2,
    RFD_BRANCH = 4'h4,
    RFD_SLEEP  = 4'h8
  } rfd_state_t;

  typedef struct packed {
    rfd_state_t      st;
    logic [1:0]      phase;
    logic [13:0]     ir;
    logic [10:0]     pc;
    logic [2:0]      pclatch;
    logic [7:0][10:0] stack;
    logic [2:0]      sp;
    logic [7:0]      acc;
    logic            c;
    logic            dc;
    logic            z;
    logic            to;
    logic            pd;
    logic [7:0]      pin_s1;
    logic [7:0]      pin_s2;
    logic            wake_s1;
    logic            wake_s2;
    logic            wr;
    logic [6:0]      wr_addr;
    logic [7:0]      wr_data;
    logic            psc_clr;
    logic            kick;
    logic            rfi;
  } rfd_regs_t;
endpackage : rfd_pkg
`default_nettype wire

/* risc_fourteen_bit_decoder_test.sv */
/*
  Self-checking testbench of the 14-bit instruction decoder core.
  Assumes rfd_pkg and rfd_core are compiled first; program and file memories are modelled here.
*/
`timescale 1ns/10ps
`default_nettype none
module risc_fourteen_bit_decoder_test;
  import rfd_pkg::*;
  logic        clk_sys_i, arst_n_i, psc_on_timer_i, wake_i;
  logic [10:0] prog_addr_o;
  logic [6:0]  file_addr_o, file_wr_addr_o;
  logic [7:0]  file_wr_data_o, port_pins_i, acc_o, status_o;
  logic        file_wr_o, psc_clear_o, wdt_kick_o, int_return_o, sleeping_o;
  logic [13:0] pmem [2048];
  logic [7:0]  fmem [128];
  int          fail_count, comparisons, psc_n, kick_n, ret_n, tbase, t;

  rfd_core dut (.clk_sys_i(clk_sys_i), .arst_n_i(arst_n_i), .prog_addr_o(prog_addr_o),
    .prog_data_i(pmem[prog_addr_o]), .file_addr_o(file_addr_o),
    .file_rd_data_i(fmem[file_addr_o]), .file_wr_o(file_wr_o),
    .file_wr_addr_o(file_wr_addr_o), .file_wr_data_o(file_wr_data_o),
    .port_pins_i(port_pins_i), .psc_on_timer_i(psc_on_timer_i), .wake_i(wake_i),
    .psc_clear_o(psc_clear_o), .wdt_kick_o(wdt_kick_o), .int_return_o(int_return_o),
    .sleeping_o(sleeping_o), .acc_o(acc_o), .status_o(status_o));

  // The clock toggles every half period of 25 ns.
  always #25 clk_sys_i = ~clk_sys_i;

  // File memory takes the write pulse; pulse counters see every one-cycle strobe.
  always @(posedge clk_sys_i) begin
    if (file_wr_o === 1'b1) fmem[file_wr_addr_o] <= file_wr_data_o;
    if (psc_clear_o === 1'b1 && file_wr_o === 1'b1 && file_wr_addr_o === FA_TIMER) psc_n++;
    if (wdt_kick_o === 1'b1) kick_n++;
    if (int_return_o === 1'b1) ret_n++;
  end

  // Instruction word builders.
  function automatic logic [13:0] bo(input logic [3:0] op, input logic d, input logic [6:0] f);
    return {2'b00, op, d, f};
  endfunction : bo
  function automatic logic [13:0] bb(input logic [1:0] k, input logic [2:0] b,
                                     input logic [6:0] f);
    return {2'b01, k, b, f};
  endfunction : bb
  function automatic logic [13:0] lit(input logic [3:0] n, input logic [7:0] k);
    return {2'b11, n, k};
  endfunction : lit
  function automatic logic [13:0] st(input logic [6:0] f);
    return bo(OP_MISC, 1'b1, f);
  endfunction : st
  function automatic logic [13:0] br(input logic g, input logic [10:0] k);
    return {2'b10, g, k};
  endfunction : br

  task automatic ld(input int a, input logic [13:0] q[$]);
    foreach (q[i]) pmem[a + i] = q[i];
  endtask : ld

  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", name, exp, got);
      fail_count++;
    end
  endtask : chk

  // Reset is held for ten cycles; the pulse counters restart with it.
  task automatic rst();
    @(posedge clk_sys_i);
    arst_n_i <= 1'b0;
    repeat (10) @(posedge clk_sys_i);
    psc_n = 0;
    kick_n = 0;
    ret_n = 0;
    arst_n_i <= 1'b1;
  endtask : rst

  // Counts cycles until the end-of-program store to 0x7f; sampled on the falling edge.
  task automatic wait_mark(output int n);
    n = 0;
    while (!(file_wr_o === 1'b1 && file_wr_addr_o === 7'h7f) && n < 3000) begin
      @(negedge clk_sys_i);
      n++;
    end
    if (n >= 3000) begin
      $display("ERROR marker expected write seen none");
      fail_count++;
    end
    repeat (2) @(negedge clk_sys_i);
  endtask : wait_mark

  task automatic stop_test();
    if (fail_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test

  // Bounded run: the whole suite needs a few hundred cycles of the 20000 allowed.
  initial begin
    #(50 * 20000);
    fail_count++;
    stop_test();
  end

  initial begin
    clk_sys_i = 1'b0;
    arst_n_i = 1'b0;
    psc_on_timer_i = 1'b0;
    wake_i = 1'b0;
    port_pins_i = 8'h00;
    fail_count = 0;
    comparisons = 0;
    foreach (pmem[i]) pmem[i] = 14'h0000;
    foreach (fmem[i]) fmem[i] = 8'h00;
    // Baseline: a lone store fixes the reference time for cycle counts.
    ld(0, '{st(7'h7f)});
    repeat (3) @(negedge clk_sys_i);
    chk("status_rst", 8'h18, status_o);
    chk("acc_rst", ACC_RST, acc_o);
    rst();
    wait_mark(tbase);
    // Logic ops with both destinations; only the zero flag moves.
    foreach (pmem[i]) pmem[i] = 14'h0000;
    ld(0, '{lit(4'h0, 8'h30), lit(LOP_IOR, 8'h05), st(7'h21), lit(LOP_XOR, 8'h35),
            bo(OP_MOV, 1'b0, FA_STATUS), st(7'h22), lit(4'h0, 8'hf0),
            bo(OP_IOR, 1'b1, 7'h20), bo(OP_XOR, 1'b0, 7'h20), st(7'h23),
            bo(OP_XOR, 1'b0, 7'h23), st(7'h7f)});
    fmem[8'h20] = 8'h0f;
    rst();
    wait_mark(t);
    chk("cycles_logic", 8'(tbase + 44), 8'(t));
    chk("or_lit", 8'h35, fmem[8'h21]);
    chk("xor_lit_status", 8'h1c, fmem[8'h22]);
    chk("or_file", 8'hff, fmem[8'h20]);
    chk("xor_file", 8'h0f, fmem[8'h23]);
    chk("status_logic", 8'h1c, status_o);
    // Literal subtract and rotations through carry; timer write with prescaler elsewhere.
    foreach (pmem[i]) pmem[i] = 14'h0000;
    ld(0, '{lit(4'h0, 8'h05), lit(4'hc, 8'h03), st(7'h21), bo(OP_MOV, 1'b0, FA_STATUS),
            st(7'h22), lit(4'h0, 8'h02), lit(4'hc, 8'h02), bo(OP_RRC, 1'b1, 7'h24),
            bo(OP_RLC, 1'b0, 7'h24), st(FA_TIMER), st(7'h7f)});
    fmem[8'h24] = 8'h80;
    rst();
    wait_mark(t);
    chk("sub_lit", 8'hfe, fmem[8'h21]);
    chk("sub_borrow_status", 8'h18, fmem[8'h22]);
    chk("rot_right", 8'hc0, fmem[8'h24]);
    chk("rot_left", 8'h80, acc_o);
    chk("status_rot", 8'h1f, status_o);
    chk("psc_off", 8'h00, 8'(psc_n));
    // Bit edits and every skip form; skipped words would clobber the accumulator.
    foreach (pmem[i]) pmem[i] = 14'h0000;
    ld(0, '{bb(2'b01, 3'd0, 7'h26), bb(2'b00, 3'd6, 7'h26), bb(2'b10, 3'd2, 7'h26),
            lit(4'h0, 8'h11), bb(2'b11, 3'd3, 7'h26), lit(4'h0, 8'h22),
            bb(2'b10, 3'd3, 7'h26), lit(4'h0, 8'h33), bb(2'b11, 3'd2, 7'h26),
            lit(LOP_IOR, 8'h40), bo(OP_DECSZ, 1'b1, 7'h27), lit(4'h0, 8'h00),
            bo(OP_INCSZ, 1'b1, 7'h28), lit(4'h0, 8'h00), bo(OP_DECSZ, 1'b1, 7'h29),
            st(7'h7f)});
    fmem[8'h26] = 8'h5a;
    fmem[8'h27] = 8'h01;
    fmem[8'h28] = 8'hff;
    fmem[8'h29] = 8'h05;
    rst();
    wait_mark(t);
    chk("cycles_skip", 8'(tbase + 60), 8'(t));
    chk("bit_edit", 8'h1b, fmem[8'h26]);
    chk("skip_acc", 8'h73, fmem[8'h7f]);
    chk("dec_skip", 8'h00, fmem[8'h27]);
    chk("inc_skip", 8'h00, fmem[8'h28]);
    chk("dec_noskip", 8'h04, fmem[8'h29]);
    chk("status_skip", 8'h18, status_o);
    // Calls, returns, goto and the watchdog kick.
    foreach (pmem[i]) pmem[i] = 14'h0000;
    ld(0, '{br(1'b0, 11'h010), st(7'h21), br(1'b0, 11'h030), br(1'b1, 11'h020)});
    ld(16, '{lit(4'h4, 8'h5c)});
    ld(32, '{st(7'h7f)});
    ld(48, '{W_KICK, br(1'b0, 11'h040), W_RETURN});
    ld(64, '{W_RETURN_FROM_INTERRUPT});
    rst();
    wait_mark(t);
    chk("cycles_ctrl", 8'(tbase + 64), 8'(t));
    chk("ret_lit", 8'h5c, fmem[8'h21]);
    chk("kick_pulses", 8'h01, 8'(kick_n));
    chk("int_ret_pulses", 8'h01, 8'(ret_n));
    // Arithmetic, logic, swap and clear forms that the other programs leave out.
    foreach (pmem[i]) pmem[i] = 14'h0000;
    ld(0, '{lit(4'h0, 8'h3a), lit(4'he, 8'h17), st(7'h30), lit(LOP_AND, 8'h0f),
            bo(OP_ADD, 1'b1, 7'h30), bo(OP_SUB, 1'b0, 7'h30), bo(OP_AND, 1'b1, 7'h30),
            bo(OP_SWAP, 1'b1, 7'h30), bo(OP_DEC, 1'b0, 7'h30), bo(OP_INC, 1'b1, 7'h31),
            bo(OP_CLR, 1'b1, 7'h32), st(7'h33), bo(OP_CLR, 1'b0, 7'h03), st(7'h7f)});
    fmem[8'h31] = 8'hff;
    fmem[8'h32] = 8'h77;
    rst();
    wait_mark(t);
    chk("byte_ops", 8'h05, fmem[8'h30]);
    chk("inc_wrap", 8'h00, fmem[8'h31]);
    chk("clear_file", 8'h00, fmem[8'h32]);
    chk("dec_to_acc", 8'h04, fmem[8'h33]);
    chk("clear_acc", 8'h00, acc_o);
    chk("status_arith", 8'h1f, status_o);
    // Timer write, pin read-back, standby and wake.
    foreach (pmem[i]) pmem[i] = 14'h0000;
    ld(0, '{lit(4'h0, 8'ha5), st(FA_TIMER), bo(OP_MOV, 1'b0, FA_TIMER),
            bo(OP_COM, 1'b1, FA_PORT), W_SLEEP, bo(OP_MOV, 1'b0, FA_STATUS), st(7'h2c),
            W_KICK, st(7'h7f)});
    fmem[FA_PORT] = 8'hff;
    @(posedge clk_sys_i);
    psc_on_timer_i <= 1'b1;
    port_pins_i <= 8'h3c;
    rst();
    repeat (80) @(negedge clk_sys_i);
    chk("sleeping", 8'h01, 8'(sleeping_o));
    chk("status_sleep", 8'h10, status_o);
    chk("psc_clear", 8'h01, 8'(psc_n));
    chk("pin_readback", 8'hc3, fmem[FA_PORT]);
    @(posedge clk_sys_i);
    wake_i <= 1'b1;
    wait_mark(t);
    chk("awake", 8'h00, 8'(sleeping_o));
    chk("status_saved", 8'h10, fmem[8'h2c]);
    chk("status_kick", 8'h18, status_o);
    stop_test();
  end
endmodule : risc_fourteen_bit_decoder_test
`default_nettype wire
